// ==== design/acc_ctrl.sv ====
// Converter control: registers, trigger, sequencing, compare and result
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/100ps
`include "acc_consts.svh"
module acc_ctrl
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Register port
  input wire acc_pkg::acc_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  // Clock sources
  input wire logic osc_out_i,
  input wire logic local_async_clock_i,
  // Hardware trigger pin
  input wire logic timer_ext_clock_pin_i,
  // Analog core
  input wire logic [11:0] sar_data_i,
  output acc_pkg::acc_mux_t mux_o,
  output logic sample_o,
  // Interrupt request
  output logic conv_irq_o
);
  import acc_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] sc1_r;
  logic [6:4] sc2_r;
  logic [7:0] cfg_r;
  logic [7:0] cv_hi_r;
  logic [7:0] cv_lo_r;
  logic timer_pin_en_r;
  logic conv_done_flag_r;
  logic active_r;
  logic cont_run_r;
  logic [11:0] res_r;
  logic [7:0] cnt_r;
  logic trig_s;
  logic trig_d_r;
  logic tick;
  logic sc1_wr;
  logic resl_rd;
  logic hw_edge;
  logic start;
  logic finish;
  logic cmp_true;
  logic [11:0] conv_val;
  logic [11:0] cmp_val;
  acc_state_t state_r;
  acc_res_t mode;
  logic [4:0] input_channel_select;
  logic channel_off;

  assign input_channel_select = sc1_r[4:0];
  assign channel_off = input_channel_select == `ACC_CH_OFF;
  assign mode = acc_res_t'(cfg_r[3:2]);
  assign sc1_wr = bus_i.wr && bus_i.addr == `ACC_OFS_SC1;
  assign resl_rd = bus_i.rd && bus_i.addr == `ACC_OFS_RESL;

  // ****************************************************************
  // Conversion clock and trigger pin
  // ****************************************************************
  acc_clk_tick u_tick
  (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .sel_i(acc_clk_t'(cfg_r[1:0])),
    .alt_clk_i(osc_out_i),
    .local_clk_i(local_async_clock_i),
    .tick_o(tick)
  );

  acc_sync u_trig
  (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .d_i(timer_ext_clock_pin_i & timer_pin_en_r),
    .q_o(trig_s)
  );

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      trig_d_r <= 1'b0;
    else
      trig_d_r <= trig_s;
  end

  assign hw_edge = trig_s & ~trig_d_r & timer_pin_en_r;

  // ****************************************************************
  // Start decision
  // ****************************************************************
  always_comb
  begin
    if (sc2_r[`ACC_SC2_TRG])
      start = hw_edge && !channel_off && !sc1_wr;
    else
      start = sc1_wr && bus_i.wdata[4:0] != `ACC_CH_OFF;
  end

  // A control write in the last tick aborts the conversion: no result, no flag
  assign finish = state_r == ACC_CONV && tick && cnt_r == 8'h01 && !sc1_wr;

  // ****************************************************************
  // Result formatting and compare
  // ****************************************************************
  always_comb
  begin
    unique case (mode)
      ACC_RES_12: conv_val = sar_data_i;
      ACC_RES_10: conv_val = {2'h0, sar_data_i[11:2]};
      default: conv_val = {4'h0, sar_data_i[11:4]};
    endcase
  end

  assign cmp_val = {cv_hi_r[3:0], cv_lo_r};
  assign cmp_true = sc2_r[`ACC_SC2_CGT] ? conv_val >= cmp_val : conv_val < cmp_val;

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_r <= ACC_IDLE;
      cnt_r <= 8'h00;
      active_r <= 1'b0;
      cont_run_r <= 1'b0;
    end
    else if (sc1_wr && !start)
    begin
      state_r <= ACC_IDLE;
      active_r <= 1'b0;
      cont_run_r <= 1'b0;
      cnt_r <= 8'h00;
    end
    else if (start)
    begin
      state_r <= ACC_CONV;
      cnt_r <= `ACC_CONV_CYC;
      active_r <= 1'b1;
      cont_run_r <= sc2_r[`ACC_SC2_TRG] ? sc1_r[`ACC_SC1_CONT] : bus_i.wdata[`ACC_SC1_CONT];
    end
    else
    begin
      unique case (state_r)
        ACC_CONV:
        begin
          if (tick)
            cnt_r <= cnt_r - 8'h01;
          if (finish)
            state_r <= ACC_DONE;
        end
        ACC_DONE:
        begin
          if (cont_run_r && !channel_off)
          begin
            state_r <= ACC_CONV;
            cnt_r <= `ACC_CONV_CYC;
          end
          else
          begin
            state_r <= ACC_IDLE;
            active_r <= 1'b0;
          end
        end
        default:
          state_r <= ACC_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Result register and done flag
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      res_r <= 12'h000;
    else if (finish && (!sc2_r[`ACC_SC2_CFE] || cmp_true))
      res_r <= conv_val;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      conv_done_flag_r <= 1'b0;
    else if (finish && !sc2_r[`ACC_SC2_CFE])
      conv_done_flag_r <= 1'b1;
    else if (finish && cmp_true)
      conv_done_flag_r <= 1'b1;
    else if (sc1_wr || resl_rd)
      conv_done_flag_r <= 1'b0;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      conv_irq_o <= 1'b0;
    else
      conv_irq_o <= conv_done_flag_r & sc1_r[`ACC_SC1_IEN];
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sc1_r <= `ACC_SC1_RST;
      sc2_r <= 3'h0;
      cfg_r <= `ACC_CFG_RST;
      cv_hi_r <= 8'h00;
      cv_lo_r <= 8'h00;
      timer_pin_en_r <= 1'b0;
    end
    else if (bus_i.wr)
    begin
      unique case (bus_i.addr)
        `ACC_OFS_SC1: sc1_r <= {1'b0, bus_i.wdata[6:0]};
        `ACC_OFS_SC2: sc2_r <= bus_i.wdata[6:4];
        `ACC_OFS_CVH: cv_hi_r <= {4'h0, bus_i.wdata[3:0]};
        `ACC_OFS_CVL: cv_lo_r <= bus_i.wdata;
        `ACC_OFS_CFG: cfg_r <= {4'h0, bus_i.wdata[3:0]};
        `ACC_OFS_SYS: timer_pin_en_r <= bus_i.wdata[0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Read data, one cycle after the strobe
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rdata_o <= 8'h00;
    else if (!bus_i.rd)
      rdata_o <= 8'h00;
    else
    begin
      unique case (bus_i.addr)
        `ACC_OFS_SC1: rdata_o <= {conv_done_flag_r, sc1_r[6:0]};
        `ACC_OFS_SC2: rdata_o <= {active_r, sc2_r, 4'h0};
        `ACC_OFS_RESH: rdata_o <= {4'h0, res_r[11:8]};
        `ACC_OFS_RESL: rdata_o <= res_r[7:0];
        `ACC_OFS_CVH: rdata_o <= cv_hi_r;
        `ACC_OFS_CVL: rdata_o <= cv_lo_r;
        `ACC_OFS_CFG: rdata_o <= cfg_r;
        `ACC_OFS_SYS: rdata_o <= {7'h00, timer_pin_en_r};
      endcase
    end
  end

  // ****************************************************************
  // Analog multiplexer control
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mux_o <= '0;
      sample_o <= 1'b0;
    end
    else
    begin
      mux_o.on <= !channel_off && state_r != ACC_IDLE;
      mux_o.channel <= (channel_off || input_channel_select == `ACC_CH_RSVD) ? 5'h00 :
        input_channel_select;
      mux_o.refh <= input_channel_select == `ACC_CH_VREFH;
      mux_o.refl <= input_channel_select == `ACC_CH_VREFL;
      sample_o <= finish;
    end
  end
endmodule

// ==== design/acc_consts.svh ====
// Constants of the converter control block: offsets, fields, resets, timing
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ACC_OFS_SC1 3'h0
`define ACC_OFS_SC2 3'h1
`define ACC_OFS_RESH 3'h2
`define ACC_OFS_RESL 3'h3
`define ACC_OFS_CVH 3'h4
`define ACC_OFS_CVL 3'h5
`define ACC_OFS_CFG 3'h6
`define ACC_OFS_SYS 3'h7

// ****************************************************************
// Field positions
// ****************************************************************
`define ACC_SC1_DONE 7
`define ACC_SC1_IEN 6
`define ACC_SC1_CONT 5
`define ACC_SC2_ACT 7
`define ACC_SC2_TRG 6
`define ACC_SC2_CFE 5
`define ACC_SC2_CGT 4
`define ACC_CH_OFF 5'h1f
`define ACC_CH_RSVD 5'h1c
`define ACC_CH_VREFH 5'h1d
`define ACC_CH_VREFL 5'h1e

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define ACC_SC1_RST 8'h1f
`define ACC_SC2_RST 8'h00
`define ACC_CFG_RST 8'h00
`define ACC_CONV_CYC 8'h14

`endif

// ==== design/acc_pkg.sv ====
// Types of the converter control block
package acc_pkg;
  typedef enum logic [1:0] {ACC_CK_BUS = 2'h0, ACC_CK_HALF = 2'h1, ACC_CK_ALT = 2'h2,
    ACC_CK_LOCAL = 2'h3} acc_clk_t;
  typedef enum logic [1:0] {ACC_RES_8 = 2'h0, ACC_RES_12 = 2'h1, ACC_RES_10 = 2'h2,
    ACC_RES_RSV = 2'h3} acc_res_t;
  typedef enum logic [2:0] {ACC_IDLE = 3'b001, ACC_CONV = 3'b010, ACC_DONE = 3'b100}
    acc_state_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acc_bus_req_t;
  typedef struct packed {
    logic on;
    logic [4:0] channel;
    logic refh;
    logic refl;
  } acc_mux_t;
endpackage

// ==== design/acc_sync.sv ====
// Two flip-flop synchroniser for one level
`timescale 1ns/100ps
module acc_sync
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Level
  input wire logic d_i,
  output logic q_o
);
  logic meta_r;

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      meta_r <= 1'b0;
      q_o <= 1'b0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// ==== design/acc_clk_tick.sv ====
// Conversion clock tick: picks one of four sources, emits a one-cycle tick
`timescale 1ns/100ps
`include "acc_consts.svh"
module acc_clk_tick
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Source select
  input wire acc_pkg::acc_clk_t sel_i,
  input wire logic alt_clk_i,
  input wire logic local_clk_i,
  // Tick
  output logic tick_o
);
  import acc_pkg::*;
  logic alt_s;
  logic loc_s;
  logic alt_d_r;
  logic loc_d_r;
  logic half_r;

  // ****************************************************************
  // Source sampling
  // ****************************************************************
  acc_sync u_alt (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .d_i(alt_clk_i), .q_o(alt_s));
  acc_sync u_loc (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .d_i(local_clk_i),
    .q_o(loc_s));

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      alt_d_r <= 1'b0;
      loc_d_r <= 1'b0;
      half_r <= 1'b0;
    end
    else
    begin
      alt_d_r <= alt_s;
      loc_d_r <= loc_s;
      half_r <= ~half_r;
    end
  end

  // ****************************************************************
  // Tick select
  // ****************************************************************
  always_comb
  begin
    unique case (sel_i)
      ACC_CK_BUS: tick_o = 1'b1;
      ACC_CK_HALF: tick_o = half_r;
      ACC_CK_ALT: tick_o = alt_s & ~alt_d_r;
      ACC_CK_LOCAL: tick_o = loc_s & ~loc_d_r;
    endcase
  end
endmodule

// ==== tb/acc_ctrl_properties.sv ====
// Concurrent checks on the ports of the converter control block
`timescale 1ns/100ps
`include "acc_consts.svh"
module acc_ctrl_properties
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Ports watched
  input wire acc_pkg::acc_bus_req_t bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic osc_out_i,
  input wire logic local_async_clock_i,
  input wire logic timer_ext_clock_pin_i,
  input wire logic [11:0] sar_data_i,
  input wire acc_pkg::acc_mux_t mux_o,
  input wire logic sample_o,
  input wire logic conv_irq_o
);
  import acc_pkg::*;
  logic [6:0] sc1_r;
  logic trg_r;
  logic cfe_r;
  logic [7:0] cnt_r;
  logic [1:0] nsmp_r;
  logic sc1wr;
  assign sc1wr = bus_i.wr && bus_i.addr == `ACC_OFS_SC1;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // ****************************************************************
  // Shadow of control bits and conversion counters
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sc1_r <= 7'h1f;
      trg_r <= 1'b0;
      cfe_r <= 1'b0;
    end
    else if (sc1wr)
      sc1_r <= bus_i.wdata[6:0];
    else if (bus_i.wr && bus_i.addr == `ACC_OFS_SC2)
    begin
      trg_r <= bus_i.wdata[6];
      cfe_r <= bus_i.wdata[5];
    end
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt_r <= 8'h00;
      nsmp_r <= 2'h0;
    end
    else
    begin
      cnt_r <= (sc1wr || sample_o) ? 8'h00 : cnt_r + {7'h0, cnt_r != 8'hff};
      nsmp_r <= sc1wr ? 2'h0 : nsmp_r + {1'b0, sample_o && nsmp_r != 2'h3};
    end
  end
  sc1_read_a: assert property (bus_i.rd && bus_i.addr == 3'h0 |=> rdata_o[6:0] == sc1_r)
    else $error("control one reads back wrong");
  off_isolate_a: assert property (sc1wr && bus_i.wdata[4:0] == 5'h1f |-> ##[1:3] !mux_o.on)
    else $error("converter not switched off");
  no_tail_a: assert property (sc1wr && bus_i.wdata[4:0] == 5'h1f |=> !sample_o [*8])
    else $error("extra conversion after stop");
  ref_high_a: assert property (sc1wr && bus_i.wdata[4:0] == 5'h1d && !trg_r |-> ##[1:3] mux_o.refh)
    else $error("high reference not selected");
  conv_len_a: assert property (sample_o |-> cnt_r >= `ACC_CONV_CYC - 1)
    else $error("conversion too short");
  single_once_a: assert property (sample_o && !sc1_r[5] && !trg_r |-> nsmp_r == 2'h0)
    else $error("more than one single conversion");
  irq_gate_a: assert property ($rose(conv_irq_o) |-> $past(sc1_r[6]))
    else $error("interrupt without enable");
  irq_follow_a: assert property (sample_o && sc1_r[6] && !cfe_r |-> ##[0:2] conv_irq_o)
    else $error("interrupt missing after conversion");
  wr_clear_a: assert property (sc1wr |-> ##[1:3] !conv_irq_o)
    else $error("flag not cleared by control write");
  low_rd_clear_a: assert property (bus_i.rd && bus_i.addr == 3'h3 |-> ##[1:3] !conv_irq_o)
    else $error("flag not cleared by result read");
  cover property (sample_o && sc1_r[5]);
  cover property ($rose(conv_irq_o));
  cover property (sample_o && trg_r);
endmodule
bind acc_ctrl acc_ctrl_properties acc_ctrl_properties_inst (.clk_sys_i(clk_sys_i),
  .resetn_i(resetn_i), .bus_i(bus_i), .rdata_o(rdata_o), .osc_out_i(osc_out_i),
  .local_async_clock_i(local_async_clock_i), .timer_ext_clock_pin_i(timer_ext_clock_pin_i),
  .sar_data_i(sar_data_i), .mux_o(mux_o), .sample_o(sample_o), .conv_irq_o(conv_irq_o));

// ==== tb/tb_top.sv ====
// Register-level testbench of the converter control block
`timescale 1ns/100ps
module tb_top;
  import acc_pkg::*;
  logic clk_sys_i;
  logic resetn_i = 1'b0;
  acc_bus_req_t bus_i = '0;
  logic [7:0] rdata_o;
  logic osc_out_i = 1'b0;
  logic local_async_clock_i = 1'b0;
  logic timer_ext_clock_pin_i = 1'b0;
  logic [11:0] sar_data_i = 12'hab5;
  acc_mux_t mux_o;
  logic sample_o;
  logic conv_irq_o;
  int err_total;
  int cmp_count;
  int nsmp;
  int cyc;
  logic [7:0] cfg_tab [4] = '{8'h00, 8'h05, 8'h0a, 8'h03};
  logic [7:0] rh_tab [4] = '{8'h00, 8'h0a, 8'h02, 8'h00};
  logic [7:0] rl_tab [4] = '{8'hab, 8'hb5, 8'had, 8'hab};
  logic [4:0] ch_tab [6] = '{5'h00, 5'h0f, 5'h10, 5'h1b, 5'h1d, 5'h1e};
  acc_ctrl acc_ctrl_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .osc_out_i(osc_out_i), .local_async_clock_i(local_async_clock_i),
    .timer_ext_clock_pin_i(timer_ext_clock_pin_i), .sar_data_i(sar_data_i),
    .mux_o(mux_o), .sample_o(sample_o), .conv_irq_o(conv_irq_o));
  // ****************************************************************
  // Clocks, slow sources and hang guard
  // ****************************************************************
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    osc_out_i <= cyc[1];
    local_async_clock_i <= cyc[2];
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end
  task automatic close_out();
    $display("errors=%0d compares=%0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    bus_i <= {a, d, 2'b10};
    @(posedge clk_sys_i);
    bus_i <= '0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    bus_i <= {a, 8'h00, 2'b01};
    @(posedge clk_sys_i);
    bus_i <= '0;
    #1 chk(rdata_o, e);
  endtask
  // Counts conversion-end pulses over a window
  task automatic ws(input int n);
    nsmp = 0;
    repeat (n)
    begin
      @(posedge clk_sys_i);
      #1 if (sample_o === 1'b1) nsmp++;
    end
  endtask
  task automatic pulse();
    @(posedge clk_sys_i);
    timer_ext_clock_pin_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    timer_ext_clock_pin_i <= 1'b0;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    rd(3'h0, 8'h1f);
    rd(3'h1, 8'h00);
    wr(3'h0, 8'h9f);
    rd(3'h0, 8'h1f);
    for (int i = 0; i < 4; i++)
    begin
      wr(3'h6, cfg_tab[i]);
      wr(3'h0, 8'h45);
      rd(3'h1, 8'h80);
      chk(mux_o, {1'b1, 5'h05, 2'b00});
      ws(600);
      chk(8'(nsmp), 8'h01);
      chk({7'h0, conv_irq_o}, 8'h01);
      chk({7'h0, mux_o.on}, 8'h00);
      rd(3'h0, 8'hc5);
      rd(3'h1, 8'h00);
      rd(3'h2, rh_tab[i]);
      rd(3'h3, rl_tab[i]);
      rd(3'h0, 8'h45);
      chk({7'h0, conv_irq_o}, 8'h00);
    end
    wr(3'h6, 8'h00);
    wr(3'h4, 8'h00);
    wr(3'h5, 8'h00);
    for (int j = 0; j < 2; j++)
    begin
      wr(3'h1, j ? 8'h30 : 8'h20);
      wr(3'h0, 8'h05);
      ws(100);
      rd(3'h0, j ? 8'h85 : 8'h05);
    end
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h06);
    repeat (10) @(posedge clk_sys_i);
    wr(3'h0, 8'h07);
    ws(100);
    chk(8'(nsmp), 8'h01);
    foreach (ch_tab[k])
    begin
      wr(3'h0, {3'h0, ch_tab[k]});
      repeat (2) @(posedge clk_sys_i);
      #1 chk({mux_o.on, mux_o.refh, mux_o.refl}, {1'b1, ch_tab[k] == 5'h1d, ch_tab[k] == 5'h1e});
      if (ch_tab[k] < 5'h1c) chk({3'h0, mux_o.channel}, {3'h0, ch_tab[k]});
    end
    wr(3'h0, 8'h1f);
    repeat (2) @(posedge clk_sys_i);
    #1 chk({7'h0, mux_o.on}, 8'h00);
    wr(3'h0, 8'h21);
    ws(100);
    chk(8'(nsmp > 1), 8'h01);
    wr(3'h0, 8'h3f);
    ws(60);
    chk(8'(nsmp), 8'h00);
    wr(3'h1, 8'h40);
    wr(3'h7, 8'h00);
    wr(3'h0, 8'h02);
    pulse();
    ws(80);
    chk(8'(nsmp), 8'h00);
    wr(3'h7, 8'h01);
    pulse();
    ws(80);
    chk(8'(nsmp), 8'h01);
    wr(3'h0, 8'h22);
    ws(40);
    chk(8'(nsmp), 8'h00);
    pulse();
    ws(100);
    chk(8'(nsmp > 1), 8'h01);
    wr(3'h0, 8'h1f);
    close_out();
  end
endmodule
